// ==== dopag_regs.vh ====
// Purpose: constants for the data operand address generator
// Assumes: included once per compile unit by bare name
// Notes:   mode codes come from the instruction decoder
`ifndef DOPAG_REGS_VH
`define DOPAG_REGS_VH

// operand modes
`define DOPAG_M_IMPL     4'h0
`define DOPAG_M_REG      4'h1
`define DOPAG_M_DIR      4'h2
`define DOPAG_M_SHORT    4'h3
`define DOPAG_M_SPECIAL  4'h4
`define DOPAG_M_IND      4'h5
`define DOPAG_M_BASED    4'h6
`define DOPAG_M_BIDX     4'h7
`define DOPAG_M_PUSH     4'h8
`define DOPAG_M_POP      4'h9
`define DOPAG_M_CALL     4'ha
`define DOPAG_M_BRK      4'hb
`define DOPAG_M_RET      4'hc
`define DOPAG_M_INTERRUPT_RETURN     4'hd

// address windows
`define DOPAG_HI_DEF     4'hf
`define DOPAG_SHORT_LO   12'hffe
`define DOPAG_SHORT_HI   12'hfff
`define DOPAG_SHORT_SPLIT 8'h20
`define DOPAG_SPECIAL_HI 12'hfff

// byte register indices and pair indices
`define DOPAG_R_X        3'h0
`define DOPAG_R_A        3'h1
`define DOPAG_R_C        3'h2
`define DOPAG_R_B        3'h3
`define DOPAG_P_BC       2'h1
`define DOPAG_P_DE       2'h2
`define DOPAG_P_HL       2'h3

// stack byte selectors
`define DOPAG_S_PSW      3'h0
`define DOPAG_S_PCHI     3'h1
`define DOPAG_S_PCMID    3'h2
`define DOPAG_S_PCLO     3'h3
`define DOPAG_S_PRHI     3'h4
`define DOPAG_S_PRLO     3'h5
`define DOPAG_S_ZERO     3'h6

// stack pointer deltas
`define DOPAG_SP_D2      16'h0002
`define DOPAG_SP_D4      16'h0004

// reset values
`define DOPAG_SP_RST     16'h0000
`define DOPAG_SEG_RST    4'h0
`define DOPAG_GPR_RST    8'h00
`endif

// ==== dopag.v ====
// Purpose: data operand address generation and stack save/restore
// Assumes: all inputs come from core logic on mclk; memory answers with mem_ack
// Notes:   one request at a time; req is ignored while busy_q is high
// Function
// - implied operands only for unsigned_multiply
// - 3-bit byte select, 2-bit pair select
// - plain direct forces upper nibble high
// - prefix takes upper nibble from seg_q
// - short direct maps onto FFE20H-FFF1FH
// - special-register field maps onto FFF00H-FFFFFH
// - indirect uses pointer pair contents
// - based adds immediate, B or BC offset to base
// - based indexed adds B or C to pair
// - stack addressed through pointer automatically
// - call stores return address below pointer
// - break/interrupt stores flags and return address
// - returns restore and raise pointer by four
// - flags pop reads pointer plus one
`timescale 1ns/1ps
`include "dopag_regs.vh"

module dopag (
	input  wire        mclk,
	input  wire        rst,
	input  wire        req,
	input  wire [3:0]  mode,
	input  wire [2:0]  byte_sel,
	input  wire [1:0]  pair_sel,
	input  wire        seg_en,
	input  wire [1:0]  base_sel,
	input  wire [1:0]  off_sel,
	input  wire        idx_sel,
	input  wire        flags_sel,
	input  wire [7:0]  imm8,
	input  wire [15:0] imm16,
	input  wire [19:0] ret_pc,
	input  wire [7:0]  flags_in,
	input  wire        gpr_we,
	input  wire [2:0]  gpr_wsel,
	input  wire [7:0]  gpr_wdata,
	input  wire        sp_we,
	input  wire [15:0] sp_wdata,
	input  wire        seg_we,
	input  wire [3:0]  seg_wdata,
	input  wire        mem_ack,
	input  wire [7:0]  mem_rdata,
	output reg  [19:0] addr_q,
	output reg         addr_valid_q,
	output reg  [7:0]  opnd_byte_q,
	output reg  [15:0] opnd_word_q,
	output reg         mem_req_q,
	output reg         mem_we_q,
	output reg  [19:0] mem_addr_q,
	output reg  [7:0]  mem_wdata_q,
	output reg         busy_q,
	output reg         done_q,
	output reg  [19:0] pc_q,
	output reg  [7:0]  flags_q,
	output reg  [15:0] sp_q,
	output reg  [3:0]  seg_q
);

	localparam ST_IDLE = 2'h0;
	localparam ST_MEM  = 2'h1;
	localparam ST_DONE = 2'h2;

	reg [7:0]  gpr_q [0:7];
	reg [1:0]  state_q;
	reg [3:0]  kind_q;
	reg        fl_q;
	reg [1:0]  pr_q;
	reg [1:0]  step_q;
	reg        cur_we_q;
	reg        cur_last_q;
	reg [2:0]  cur_sel_q;
	reg [15:0] delta_q;
	reg        up_q;
	reg [19:0] ea_d;
	reg [3:0]  hi_d;
	reg [15:0] base_d;
	reg [15:0] off_d;
	reg [8:0]  tbl_d;
	reg [3:0]  tkind_d;
	reg        tfl_d;
	reg [1:0]  tstep_d;
	reg [7:0]  wbyte_d;
	reg [1:0]  wpair_d;
	integer    i;

	function [15:0] pair_val;
		input [1:0] p;
		begin
			pair_val = {gpr_q[{p, 1'b1}], gpr_q[{p, 1'b0}]};
		end
	endfunction

	// table entry {last, we, sel, off} for one stack step
	function [8:0] stk_step;
		input [3:0] k;
		input       fl;
		input [1:0] s;
		begin
			stk_step = {1'b1, 1'b0, `DOPAG_S_ZERO, 4'h0};
			case (k)
				`DOPAG_M_PUSH:
					if (s == 2'h0)
						stk_step = {1'b0, 1'b1, (fl ? `DOPAG_S_PSW : `DOPAG_S_PRHI), 4'hf};
					else
						stk_step = {1'b1, 1'b1, (fl ? `DOPAG_S_ZERO : `DOPAG_S_PRLO), 4'he};
				`DOPAG_M_POP:
					if (fl)
						stk_step = {1'b1, 1'b0, `DOPAG_S_PSW, 4'h1};
					else if (s == 2'h0)
						stk_step = {1'b0, 1'b0, `DOPAG_S_PRLO, 4'h0};
					else
						stk_step = {1'b1, 1'b0, `DOPAG_S_PRHI, 4'h1};
				`DOPAG_M_CALL:
					case (s)
						2'h0: stk_step = {1'b0, 1'b1, `DOPAG_S_PCHI, 4'he};
						2'h1: stk_step = {1'b0, 1'b1, `DOPAG_S_PCMID, 4'hd};
						default: stk_step = {1'b1, 1'b1, `DOPAG_S_PCLO, 4'hc};
					endcase
				`DOPAG_M_BRK:
					case (s)
						2'h0: stk_step = {1'b0, 1'b1, `DOPAG_S_PSW, 4'hf};
						2'h1: stk_step = {1'b0, 1'b1, `DOPAG_S_PCHI, 4'he};
						2'h2: stk_step = {1'b0, 1'b1, `DOPAG_S_PCMID, 4'hd};
						default: stk_step = {1'b1, 1'b1, `DOPAG_S_PCLO, 4'hc};
					endcase
				`DOPAG_M_RET, `DOPAG_M_INTERRUPT_RETURN:
					case (s)
						2'h0: stk_step = {1'b0, 1'b0, `DOPAG_S_PCLO, 4'h0};
						2'h1: stk_step = {1'b0, 1'b0, `DOPAG_S_PCMID, 4'h1};
						2'h2: stk_step = {(k == `DOPAG_M_RET), 1'b0, `DOPAG_S_PCHI, 4'h2};
						default: stk_step = {1'b1, 1'b0, `DOPAG_S_PSW, 4'h3};
					endcase
				default: stk_step = {1'b1, 1'b0, `DOPAG_S_ZERO, 4'h0};
			endcase
		end
	endfunction

	// operand address forming
	always @*
	begin
		// no prefix forces upper nibble high
		hi_d = seg_en ? seg_q : `DOPAG_HI_DEF;
		case (base_sel)
			2'h0: base_d = pair_val(`DOPAG_P_HL);
			2'h1: base_d = pair_val(`DOPAG_P_DE);
			2'h2: base_d = sp_q;
			default: base_d = imm16;
		endcase
		case (off_sel)
			2'h0: off_d = {8'h00, imm8};
			2'h1: off_d = imm16;
			2'h2: off_d = {8'h00, gpr_q[`DOPAG_R_B]};
			default: off_d = pair_val(`DOPAG_P_BC);
		endcase
		case (mode)
			`DOPAG_M_DIR: ea_d = {hi_d, imm16};
			// field values below 20H wrap to FFFxxH
			`DOPAG_M_SHORT:
				ea_d = (imm8 >= `DOPAG_SHORT_SPLIT) ? {`DOPAG_SHORT_LO, imm8} : {`DOPAG_SHORT_HI, imm8};
			`DOPAG_M_SPECIAL: ea_d = {`DOPAG_SPECIAL_HI, imm8};
			`DOPAG_M_IND: ea_d = {hi_d, (pair_sel[0] ? pair_val(`DOPAG_P_HL) : pair_val(`DOPAG_P_DE))};
			`DOPAG_M_BASED: ea_d = {hi_d, base_d + off_d};
			// primary pair plus B or C
			`DOPAG_M_BIDX:
				ea_d = {hi_d, pair_val(`DOPAG_P_HL)
					+ {8'h00, (idx_sel ? gpr_q[`DOPAG_R_B] : gpr_q[`DOPAG_R_C])}};
			default: ea_d = 20'h00000;
		endcase
	end

	// next stack step; idle looks at the incoming request
	always @*
	begin
		tkind_d = (state_q == ST_IDLE) ? mode : kind_q;
		tfl_d   = (state_q == ST_IDLE) ? flags_sel : fl_q;
		tstep_d = (state_q == ST_IDLE) ? 2'h0 : step_q + 2'h1;
		tbl_d   = stk_step(tkind_d, tfl_d, tstep_d);
		wpair_d = (state_q == ST_IDLE) ? pair_sel : pr_q;
		case (tbl_d[6:4])
			`DOPAG_S_PSW:   wbyte_d = flags_in;
			`DOPAG_S_PCHI:  wbyte_d = {4'h0, ret_pc[19:16]};
			`DOPAG_S_PCMID: wbyte_d = ret_pc[15:8];
			`DOPAG_S_PCLO:  wbyte_d = ret_pc[7:0];
			`DOPAG_S_PRHI:  wbyte_d = gpr_q[{wpair_d, 1'b1}];
			`DOPAG_S_PRLO:  wbyte_d = gpr_q[{wpair_d, 1'b0}];
			default:        wbyte_d = 8'h00;
		endcase
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			for (i = 0; i < 8; i = i + 1)
				gpr_q[i] <= `DOPAG_GPR_RST;
			state_q      <= ST_IDLE;
			kind_q       <= 4'h0;
			fl_q         <= 1'b0;
			pr_q         <= 2'h0;
			step_q       <= 2'h0;
			cur_we_q     <= 1'b0;
			cur_last_q   <= 1'b0;
			cur_sel_q    <= 3'h0;
			delta_q      <= 16'h0000;
			up_q         <= 1'b0;
			addr_q       <= 20'h00000;
			addr_valid_q <= 1'b0;
			opnd_byte_q  <= 8'h00;
			opnd_word_q  <= 16'h0000;
			mem_req_q    <= 1'b0;
			mem_we_q     <= 1'b0;
			mem_addr_q   <= 20'h00000;
			mem_wdata_q  <= 8'h00;
			busy_q       <= 1'b0;
			done_q       <= 1'b0;
			pc_q         <= 20'h00000;
			flags_q      <= 8'h00;
			sp_q         <= `DOPAG_SP_RST;
			seg_q        <= `DOPAG_SEG_RST;
		end
		else
		begin
			addr_valid_q <= 1'b0;
			done_q       <= 1'b0;
			if (gpr_we)
				gpr_q[gpr_wsel] <= gpr_wdata;
			if (seg_we)
				seg_q <= seg_wdata;
			if (sp_we && state_q == ST_IDLE)
				sp_q <= sp_wdata;
			case (state_q)
				ST_IDLE:
					if (req)
					begin
						if (mode[3])
						begin
							kind_q      <= mode;
							fl_q        <= flags_sel;
							pr_q        <= pair_sel;
							step_q      <= 2'h0;
							up_q        <= (mode == `DOPAG_M_POP) || (mode == `DOPAG_M_RET)
								|| (mode == `DOPAG_M_INTERRUPT_RETURN);
							delta_q     <= (mode == `DOPAG_M_PUSH || mode == `DOPAG_M_POP) ?
								`DOPAG_SP_D2 : `DOPAG_SP_D4;
							cur_we_q    <= tbl_d[7];
							cur_last_q  <= tbl_d[8];
							cur_sel_q   <= tbl_d[6:4];
							mem_req_q   <= 1'b1;
							mem_we_q    <= tbl_d[7];
							mem_addr_q  <= {`DOPAG_HI_DEF, sp_q + {{12{tbl_d[3]}}, tbl_d[3:0]}};
							mem_wdata_q <= wbyte_d;
							busy_q      <= 1'b1;
							state_q     <= ST_MEM;
						end
						else
						begin
							addr_q       <= ea_d;
							addr_valid_q <= 1'b1;
							// implied operands fixed as A and X
							if (mode == `DOPAG_M_IMPL)
							begin
								opnd_byte_q <= gpr_q[`DOPAG_R_X];
								opnd_word_q <= {8'h00, gpr_q[`DOPAG_R_A]};
							end
							else
							begin
								opnd_byte_q <= gpr_q[byte_sel];
								opnd_word_q <= pair_val(pair_sel);
							end
						end
					end
				ST_MEM:
					if (mem_ack)
					begin
						if (!cur_we_q)
						begin
							case (cur_sel_q)
								`DOPAG_S_PSW:   flags_q <= mem_rdata;
								`DOPAG_S_PCHI:  pc_q[19:16] <= mem_rdata[3:0];
								`DOPAG_S_PCMID: pc_q[15:8] <= mem_rdata;
								`DOPAG_S_PCLO:  pc_q[7:0] <= mem_rdata;
								`DOPAG_S_PRHI:  gpr_q[{pr_q, 1'b1}] <= mem_rdata;
								`DOPAG_S_PRLO:  gpr_q[{pr_q, 1'b0}] <= mem_rdata;
								default:        flags_q <= flags_q;
							endcase
						end
						if (cur_last_q)
						begin
							mem_req_q <= 1'b0;
							mem_we_q  <= 1'b0;
							state_q   <= ST_DONE;
						end
						else
						begin
							step_q      <= tstep_d;
							cur_we_q    <= tbl_d[7];
							cur_last_q  <= tbl_d[8];
							cur_sel_q   <= tbl_d[6:4];
							mem_we_q    <= tbl_d[7];
							mem_addr_q  <= {`DOPAG_HI_DEF, sp_q + {{12{tbl_d[3]}}, tbl_d[3:0]}};
							mem_wdata_q <= wbyte_d;
						end
					end
				ST_DONE:
				begin
					// pointer moves only after all bytes, so offsets stay relative to the old value
					// raise by delta on restore
					sp_q    <= up_q ? sp_q + delta_q : sp_q - delta_q;
					done_q  <= 1'b1;
					busy_q  <= 1'b0;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule

// ==== dopag_properties.sv ====
// Purpose: port checks for the data operand address generator
// Assumes: one mclk domain, rst synchronous active high
// Notes:   pointer deltas judged at done_q against the start value
`timescale 1ns/1ps
`include "dopag_regs.vh"

module dopag_props (
	input wire        mclk,
	input wire        rst,
	input wire        req,
	input wire [3:0]  mode,
	input wire        seg_en,
	input wire [7:0]  imm8,
	input wire [15:0] imm16,
	input wire        busy_q,
	input wire        addr_valid_q,
	input wire [19:0] addr_q,
	input wire        mem_req_q,
	input wire        mem_ack,
	input wire [19:0] mem_addr_q,
	input wire        done_q,
	input wire [15:0] sp_q,
	input wire [3:0]  seg_q
);
	reg [15:0] sp0_q;
	reg [3:0]  md_q;
	wire       go_a = req && !busy_q && mode < 4'h8;
	wire       go_s = req && !busy_q && mode >= 4'h8;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (rst);
	// start pointer kept, since sp_q only moves after the last byte
	always @(posedge mclk)
	begin
		if (rst)
		begin
			sp0_q <= 16'h0000;
			md_q  <= 4'h0;
		end
		else if (go_s)
		begin
			sp0_q <= sp_q;
			md_q  <= mode;
		end
	end
	property p_lat;
		go_a |=> addr_valid_q;
	endproperty
	a_lat: assert property (p_lat) else $error("address not valid after request");
	property p_dir;
		go_a && mode == `DOPAG_M_DIR && !seg_en |=> addr_q == {4'hf, $past(imm16)};
	endproperty
	a_dir: assert property (p_dir) else $error("direct address wrong");
	property p_seg;
		go_a && mode == `DOPAG_M_DIR && seg_en |=> addr_q == {$past(seg_q), $past(imm16)};
	endproperty
	a_seg: assert property (p_seg) else $error("prefixed address wrong");
	property p_short;
		go_a && mode == `DOPAG_M_SHORT |=> addr_q[7:0] == $past(imm8)
			&& addr_q[19:8] == (($past(imm8) >= 8'h20) ? 12'hffe : 12'hfff);
	endproperty
	a_short: assert property (p_short) else $error("short direct address wrong");
	property p_spec;
		go_a && mode == `DOPAG_M_SPECIAL |=> addr_q == {12'hfff, $past(imm8)};
	endproperty
	a_spec: assert property (p_spec) else $error("special address wrong");
	property p_stk;
		go_s |=> busy_q && mem_req_q && mem_addr_q[19:16] == 4'hf;
	endproperty
	a_stk: assert property (p_stk) else $error("stack access not started");
	property p_hold;
		mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q);
	endproperty
	a_hold: assert property (p_hold) else $error("stack access dropped before ack");
	property p_call;
		done_q && (md_q == `DOPAG_M_CALL || md_q == `DOPAG_M_BRK) |-> sp_q == sp0_q - 16'h0004;
	endproperty
	a_call: assert property (p_call) else $error("pointer not lowered by four");
	property p_ret;
		done_q && (md_q == `DOPAG_M_RET || md_q == `DOPAG_M_INTERRUPT_RETURN) |-> sp_q == sp0_q + 16'h0004;
	endproperty
	a_ret: assert property (p_ret) else $error("pointer not raised by four");
	property p_pp;
		done_q && md_q == `DOPAG_M_PUSH |-> sp_q == sp0_q - 16'h0002;
	endproperty
	a_pp: assert property (p_pp) else $error("push pointer step wrong");
	property p_pop;
		done_q && md_q == `DOPAG_M_POP |-> sp_q == sp0_q + 16'h0002;
	endproperty
	a_pop: assert property (p_pop) else $error("pop pointer step wrong");
	c_call: cover property (done_q && md_q == `DOPAG_M_CALL);
	c_wait: cover property (mem_req_q && !mem_ack);
	c_seg: cover property (go_a && seg_en);
	c_ret: cover property (done_q && md_q == `DOPAG_M_INTERRUPT_RETURN);
endmodule

bind dopag dopag_props dopag_props_i (.mclk, .rst, .req, .mode, .seg_en, .imm8, .imm16, .busy_q,
	.addr_valid_q, .addr_q, .mem_req_q, .mem_ack, .mem_addr_q, .done_q, .sp_q, .seg_q);

// ==== dopag_mem_model.sv ====
// Purpose: stack RAM answering dopag byte accesses
// Assumes: low address byte picks the cell
// Notes:   slow adds two wait cycles; idle read data is scrambled
`timescale 1ns/1ps

module dopag_mem_model (
	input  wire        mclk,
	input  wire        rst,
	input  wire        slow,
	input  wire        mem_req_q,
	input  wire        mem_we_q,
	input  wire [19:0] mem_addr_q,
	input  wire [7:0]  mem_wdata_q,
	output wire        mem_ack,
	output wire [7:0]  mem_rdata
);
	reg [7:0] ram [0:255];
	reg [1:0] wt_q;
	reg [7:0] last_q;
	assign mem_ack   = mem_req_q && (!slow || wt_q == 2'h2);
	assign mem_rdata = mem_ack ? ram[mem_addr_q[7:0]] : ~last_q;
	always @(posedge mclk)
	begin
		if (rst || !mem_req_q || mem_ack)
			wt_q <= 2'h0;
		else
			wt_q <= wt_q + 2'h1;
		if (mem_ack && mem_we_q)
			ram[mem_addr_q[7:0]] <= mem_wdata_q;
		if (mem_ack)
			last_q <= mem_rdata;
	end
endmodule

// ==== dopag_tb.sv ====
// Purpose: self-checking bench for dopag
// Assumes: inputs change on falling mclk
// Notes:   gpr i preset to 10h+i
`timescale 1ns/1ps
`include "dopag_regs.vh"

module dopag_tb;
	reg mclk = 0, rst = 1, req = 0, seg_en = 0, idx_sel = 0, flags_sel = 0, slow = 0;
	reg gpr_we = 0, sp_we = 0, seg_we = 0;
	reg [3:0] mode = 0, seg_wdata = 0;
	reg [2:0] byte_sel = 0, gpr_wsel = 0;
	reg [1:0] pair_sel = 0, base_sel = 0, off_sel = 0;
	reg [7:0] imm8 = 0, flags_in = 0, gpr_wdata = 0;
	reg [15:0] imm16 = 0, sp_wdata = 0;
	reg [19:0] ret_pc = 0;
	wire mem_ack, addr_valid_q, mem_req_q, mem_we_q, busy_q, done_q;
	wire [7:0] mem_rdata, opnd_byte_q, mem_wdata_q, flags_q;
	wire [15:0] opnd_word_q, sp_q;
	wire [19:0] addr_q, mem_addr_q, pc_q;
	wire [3:0] seg_q;
	integer n_mismatch = 0, comparisons = 0, i;
	dopag dopag_i (.mclk, .rst, .req, .mode, .byte_sel, .pair_sel, .seg_en, .base_sel, .off_sel,
		.idx_sel, .flags_sel, .imm8, .imm16, .ret_pc, .flags_in, .gpr_we, .gpr_wsel, .gpr_wdata,
		.sp_we, .sp_wdata, .seg_we, .seg_wdata, .mem_ack, .mem_rdata, .addr_q, .addr_valid_q,
		.opnd_byte_q, .opnd_word_q, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .busy_q,
		.done_q, .pc_q, .flags_q, .sp_q, .seg_q);
	dopag_mem_model dopag_mem_model_i (.mclk, .rst, .slow, .mem_req_q, .mem_we_q, .mem_addr_q,
		.mem_wdata_q, .mem_ack, .mem_rdata);
	always #4 mclk = ~mclk;
	task ck(input string n, input [31:0] g, input [31:0] e);
	begin
		comparisons = comparisons + 1;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			n_mismatch = n_mismatch + 1;
		end
	end
	endtask
	task print_verdict;
	begin
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	// strobe one request, then wait bounded for its completion flag
	task go(input [3:0] m);
		integer k;
	begin
		mode = m;
		req = 1;
		@(negedge mclk);
		req = 0;
		k = 0;
		while (addr_valid_q !== 1'b1 && done_q !== 1'b1 && k < 40)
		begin
			@(negedge mclk);
			k = k + 1;
		end
		// a limit that runs out is a mismatch, not a silent return
		ck("wait", {31'h0, k < 40}, 32'h1);
		if (m[3])
			ck("busy_q", busy_q, 32'h0);
		else
			ck("latency", k, 32'h0);
		// one edge with req low keeps strobes apart
		@(negedge mclk);
	end
	endtask
	task ga(input [3:0] m, input [19:0] e);
	begin
		go(m);
		ck("addr_q", addr_q, e);
	end
	endtask
	function [7:0] rm(input [7:0] a);
		rm = dopag_mem_model_i.ram[a];
	endfunction
	task t_regs;
	begin
		ck("sp_q", sp_q, 20'h0);
		for (i = 0; i < 8; i = i + 1)
		begin
			gpr_we = 1;
			gpr_wsel = i[2:0];
			gpr_wdata = 8'h10 + i[7:0];
			@(negedge mclk);
		end
		gpr_we = 0;
		go(`DOPAG_M_IMPL);
		ck("impl_b", opnd_byte_q, 20'h10);
		ck("impl_w", opnd_word_q, 20'h0011);
		byte_sel = 3'h5;
		pair_sel = 2'h3;
		go(`DOPAG_M_REG);
		ck("reg_b", opnd_byte_q, 20'h15);
		ck("reg_w", opnd_word_q, 20'h1716);
	end
	endtask
	task t_direct;
	begin
		imm16 = 16'h1234;
		ga(`DOPAG_M_DIR, 20'hf1234);
		seg_we = 1;
		seg_wdata = 4'h3;
		@(negedge mclk);
		seg_we = 0;
		seg_en = 1;
		ga(`DOPAG_M_DIR, 20'h31234);
		seg_en = 0;
	end
	endtask
	task t_windows;
	begin
		imm8 = 8'h20;
		ga(`DOPAG_M_SHORT, 20'hffe20);
		imm8 = 8'h1e;
		ga(`DOPAG_M_SHORT, 20'hfff1e);
		ga(`DOPAG_M_SPECIAL, 20'hfff1e);
		imm8 = 8'hfe;
		ga(`DOPAG_M_SPECIAL, 20'hffffe);
	end
	endtask
	task t_pointer;
	begin
		ga(`DOPAG_M_IND, 20'hf1716);
		pair_sel = 2'h2;
		seg_en = 1;
		ga(`DOPAG_M_IND, 20'h31514);
		seg_en = 0;
		imm8 = 8'hff;
		ga(`DOPAG_M_BASED, 20'hf1815);
		base_sel = 2'h3;
		imm16 = 16'hffff;
		off_sel = 2'h2;
		ga(`DOPAG_M_BASED, 20'hf0012);
		base_sel = 2'h1;
		off_sel = 2'h3;
		ga(`DOPAG_M_BASED, 20'hf2826);
		base_sel = 2'h0;
		off_sel = 2'h1;
		ga(`DOPAG_M_BASED, 20'hf1715);
		base_sel = 2'h2;
		off_sel = 2'h0;
		imm8 = 8'h44;
		ga(`DOPAG_M_BASED, 20'hf0044);
		idx_sel = 1;
		ga(`DOPAG_M_BIDX, 20'hf1729);
		idx_sel = 0;
		ga(`DOPAG_M_BIDX, 20'hf1728);
	end
	endtask
	task t_stack;
	begin
		sp_we = 1;
		sp_wdata = 16'hfe80;
		@(negedge mclk);
		sp_we = 0;
		ret_pc = 20'h5a1c3;
		go(`DOPAG_M_CALL);
		ck("call", {rm(8'h7e), rm(8'h7d), rm(8'h7c)}, 32'h0005a1c3);
		ck("sp_q", sp_q, 20'hfe7c);
		ret_pc = 0;
		go(`DOPAG_M_RET);
		ck("pc_q", pc_q, 20'h5a1c3);
		slow = 1;
		flags_in = 8'h96;
		ret_pc = 20'h9b2d4;
		go(`DOPAG_M_BRK);
		ck("brk", {rm(8'h7f), rm(8'h7e), rm(8'h7d), rm(8'h7c)}, 32'h9609b2d4);
		ret_pc = 0;
		go(`DOPAG_M_INTERRUPT_RETURN);
		ck("interrupt_return", {flags_q, pc_q}, 32'h0969b2d4);
		ck("sp_q", sp_q, 20'hfe80);
		slow = 0;
		pair_sel = 2'h3;
		go(`DOPAG_M_PUSH);
		flags_sel = 1;
		flags_in = 8'h3c;
		go(`DOPAG_M_PUSH);
		ck("push", {rm(8'h7f), rm(8'h7e), rm(8'h7d), rm(8'h7c)}, 32'h17163c00);
		go(`DOPAG_M_POP);
		ck("flags_q", flags_q, 20'h3c);
		flags_sel = 0;
		pair_sel = 2'h1;
		go(`DOPAG_M_POP);
		ck("sp_q", sp_q, 20'hfe80);
		go(`DOPAG_M_REG);
		ck("pop_w", opnd_word_q, 20'h1716);
	end
	endtask
	initial
	begin
		repeat (20) @(negedge mclk);
		rst = 0;
		t_regs;
		t_direct;
		t_windows;
		t_pointer;
		t_stack;
		print_verdict;
	end
	initial
	begin
		#20000;
		n_mismatch = n_mismatch + 1;
		print_verdict;
	end
endmodule
